// [verilog/bbd_pkg.sv]
// Shared constants for the branch and bit-operation decoder.
// Assumes an 8-bit core with one clock; no timing constants beyond cycle counts.
`default_nettype none
package bbd_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [4:0] ABS_CALL_LO = 5'h11;
	localparam logic [4:0] ABS_JMP_LO = 5'h01;
	localparam int ABS_HI_MSB = 7;
	localparam int ABS_HI_LSB = 5;
	localparam logic [7:0] OP_RJMP = 8'h80;
	localparam logic [7:0] OP_JMPI = 8'h73;
	localparam logic [7:0] OP_JZ = 8'h60;
	localparam logic [7:0] OP_JNZ = 8'h70;
	localparam logic [7:0] OP_JC = 8'h40;
	localparam logic [7:0] OP_JNC = 8'h50;
	localparam logic [7:0] OP_JB = 8'h20;
	localparam logic [7:0] OP_JNB = 8'h30;
	localparam logic [7:0] OP_JBCL = 8'h10;
	localparam logic [7:0] OP_CJ_DIR = 8'hB5;
	localparam logic [7:0] OP_CJ_IMM = 8'hB4;
	localparam logic [7:0] OP_CJ_IND = 8'hB6;
	localparam logic [7:0] OP_CJ_REG = 8'hB8;
	localparam logic [7:0] OP_DJ_REG = 8'hD8;
	localparam logic [7:0] OP_DJ_DIR = 8'hD5;
	localparam logic [7:0] OP_ANL_C = 8'h82;
	localparam logic [7:0] OP_ANL_CN = 8'hB0;
	localparam logic [7:0] OP_ORL_C = 8'h72;
	localparam logic [7:0] OP_ORL_CN = 8'hA0;
	localparam logic [7:0] OP_MOV_CB = 8'hA2;
	localparam logic [7:0] OP_MOV_BC = 8'h92;
	localparam logic [7:0] OP_BRK = 8'hA5;
	localparam logic [7:0] OP_SETB_C = 8'hD3;
	localparam logic [7:0] OP_CLR_C = 8'hC3;
	localparam logic [7:0] OP_CPL_C = 8'hB3;
	localparam logic [7:0] REG_MASK = 8'hF8;
	localparam logic [7:0] IND_MASK = 8'hFE;
	// ----------------------------------------------------------------
	// Lengths and cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [2:0] CYC_ABSCALL = 3'h6;
	localparam logic [2:0] CYC_ABSJMP = 3'h3;
	localparam logic [2:0] CYC_REL = 3'h3;
	localparam logic [2:0] CYC_JMPI = 3'h2;
	localparam logic [2:0] CYC_BIT_BR = 3'h4;
	localparam logic [2:0] CYC_CMPJ = 3'h4;
	localparam logic [2:0] CYC_DJ_REG = 3'h3;
	localparam logic [2:0] CYC_DJ_DIR = 3'h4;
	localparam logic [2:0] CYC_CBIT = 3'h2;
	localparam logic [2:0] CYC_MOVBC = 3'h3;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic RST_FLAG = 1'b0;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		CL_NONE = 5'b00000, CL_ABSCALL = 5'b00001, CL_ABSJMP = 5'b00010, CL_RJMP = 5'b00011,
		CL_JMPI = 5'b00100, CL_JZ = 5'b00101, CL_JNZ = 5'b00110, CL_JC = 5'b00111,
		CL_JNC = 5'b01000, CL_JB = 5'b01001, CL_JNB = 5'b01010, CL_JBCL = 5'b01011,
		CL_CJ_DIR = 5'b01100, CL_CJ_IMM = 5'b01101, CL_CJ_MEM = 5'b01110, CL_DJ_REG = 5'b01111,
		CL_DJ_DIR = 5'b10000, CL_ANL = 5'b10001, CL_ANLN = 5'b10010, CL_ORL = 5'b10011,
		CL_ORLN = 5'b10100, CL_MOVCB = 5'b10101, CL_MOVBC = 5'b10110, CL_BRK = 5'b10111,
		CL_SETC = 5'b11000, CL_CLRC = 5'b11001, CL_CPLC = 5'b11010
	} bbd_cls_e;
	typedef enum logic [1:0] {MD_DIRECT = 2'b00, MD_REG = 2'b01, MD_IND = 2'b10, MD_NONE = 2'b11} bbd_mode_e;
	typedef enum logic [1:0] {ALU_NONE = 2'b00, ALU_FULL = 2'b01, ALU_MULDIV = 2'b10, ALU_C_ONLY = 2'b11} bbd_alu_e;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH2 = 2'b01, ST_FETCH3 = 2'b10, ST_EXEC = 2'b11} bbd_state_e;
endpackage
`default_nettype wire

// [verilog/bbd_op_decode.sv]
// Opcode classifier: class, length, cycle count and operand mode.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
`default_nettype none
module bbd_op_decode import bbd_pkg::*; (
	// Opcode in
	input wire logic [7:0] op,
	// Decode out
	output bbd_cls_e cls,
	output logic [1:0] nbytes,
	output logic [2:0] ncyc,
	output bbd_mode_e mode
);
	// ----------------------------------------------------------------
	// Classification
	// ----------------------------------------------------------------
	// Masked groups first, then the single opcodes; anything else is foreign
	always_comb begin
		cls = CL_NONE;
		nbytes = LEN_1;
		ncyc = CYC_ONE;
		mode = MD_NONE;
		if (op[4:0] == ABS_CALL_LO) begin
			cls = CL_ABSCALL; nbytes = LEN_2; ncyc = CYC_ABSCALL;
		end else if (op[4:0] == ABS_JMP_LO) begin
			cls = CL_ABSJMP; nbytes = LEN_2; ncyc = CYC_ABSJMP;
		end else if ((op & REG_MASK) == OP_CJ_REG) begin
			cls = CL_CJ_MEM; nbytes = LEN_3; ncyc = CYC_CMPJ; mode = MD_REG;
		end else if ((op & IND_MASK) == OP_CJ_IND) begin
			cls = CL_CJ_MEM; nbytes = LEN_3; ncyc = CYC_CMPJ; mode = MD_IND;
		end else if ((op & REG_MASK) == OP_DJ_REG) begin
			cls = CL_DJ_REG; nbytes = LEN_2; ncyc = CYC_DJ_REG; mode = MD_REG;
		end else begin
			case (op)
				OP_RJMP: begin cls = CL_RJMP; nbytes = LEN_2; ncyc = CYC_REL; end
				OP_JMPI: begin cls = CL_JMPI; ncyc = CYC_JMPI; end
				OP_JZ: begin cls = CL_JZ; nbytes = LEN_2; ncyc = CYC_REL; end
				OP_JNZ: begin cls = CL_JNZ; nbytes = LEN_2; ncyc = CYC_REL; end
				OP_JC: begin cls = CL_JC; nbytes = LEN_2; ncyc = CYC_REL; end
				OP_JNC: begin cls = CL_JNC; nbytes = LEN_2; ncyc = CYC_REL; end
				OP_JB: begin cls = CL_JB; nbytes = LEN_3; ncyc = CYC_BIT_BR; mode = MD_DIRECT; end
				OP_JNB: begin cls = CL_JNB; nbytes = LEN_3; ncyc = CYC_BIT_BR; mode = MD_DIRECT; end
				OP_JBCL: begin cls = CL_JBCL; nbytes = LEN_3; ncyc = CYC_BIT_BR; mode = MD_DIRECT; end
				OP_CJ_DIR: begin cls = CL_CJ_DIR; nbytes = LEN_3; ncyc = CYC_CMPJ; mode = MD_DIRECT; end
				OP_CJ_IMM: begin cls = CL_CJ_IMM; nbytes = LEN_3; ncyc = CYC_CMPJ; end
				OP_DJ_DIR: begin cls = CL_DJ_DIR; nbytes = LEN_3; ncyc = CYC_DJ_DIR; mode = MD_DIRECT; end
				OP_ANL_C: begin cls = CL_ANL; nbytes = LEN_2; ncyc = CYC_CBIT; mode = MD_DIRECT; end
				OP_ANL_CN: begin cls = CL_ANLN; nbytes = LEN_2; ncyc = CYC_CBIT; mode = MD_DIRECT; end
				OP_ORL_C: begin cls = CL_ORL; nbytes = LEN_2; ncyc = CYC_CBIT; mode = MD_DIRECT; end
				OP_ORL_CN: begin cls = CL_ORLN; nbytes = LEN_2; ncyc = CYC_CBIT; mode = MD_DIRECT; end
				OP_MOV_CB: begin cls = CL_MOVCB; nbytes = LEN_2; ncyc = CYC_CBIT; mode = MD_DIRECT; end
				OP_MOV_BC: begin cls = CL_MOVBC; nbytes = LEN_2; ncyc = CYC_MOVBC; mode = MD_DIRECT; end
				OP_BRK: cls = CL_BRK;
				OP_SETB_C: cls = CL_SETC;
				OP_CLR_C: cls = CL_CLRC;
				OP_CPL_C: cls = CL_CPLC;
				default: cls = CL_NONE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [verilog/bbd_core.sv]
// Branch, boolean-bit and carry-flag execution unit of an 8-bit core.
// Assumes the fetch path offers one byte per cycle and operand inputs are same-clock core logic.
//
// Notes on behaviour
// - Absolute call/jump: target bits 10:8 from opcode 7:5, bits 7:0 from byte two.
// - Opcode 80 is a two-byte relative jump taking three cycles.
// - Opcode 73 jumps to accumulator plus data pointer in two cycles.
// - Opcodes 60/70 branch on zero/nonzero accumulator, two bytes, three cycles.
// - Opcodes 40/50 branch on carry set/clear, two bytes, three cycles.
// - Opcodes 20/30 branch on addressed bit one/zero, three bytes, four cycles.
// - Opcode 10 branches on bit one and clears that bit.
// - Compare accumulator with direct or immediate byte, branch when unequal.
// - Compare working register with immediate, branch when unequal.
// - Compare indirect byte through R0/R1 with immediate, branch when unequal.
// - Decrement register or direct byte, branch when result nonzero.
// - AND carry with addressed bit or its complement, two cycles.
// - OR carry with addressed bit or its complement, two cycles.
// - Move bit to carry in two cycles, carry to bit in three.
// - Opcode A5 is a one-cycle breakpoint acting in debug mode.
// - Add/subtract update all three flags; carry-only ops leave others untouched.
// - Multiply/divide clear carry and take overflow from the unit; set-carry forces carry one.
`timescale 1ns/1ps
`default_nettype none
module bbd_core import bbd_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction fetch
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_byte,
	input wire logic [15:0] fetch_pc,
	output logic fetch_ready_r,
	// Operands from the datapath
	input wire logic [7:0] acc_in,
	input wire logic [15:0] data_pointer_16,
	input wire logic [7:0] mem_in,
	input wire logic bit_in,
	input wire logic debug_mode_in,
	// Flag results from the arithmetic unit
	input wire logic alu_valid_in,
	input wire bbd_alu_e alu_kind_in,
	input wire logic alu_carry_in,
	input wire logic alu_ovf_in,
	input wire logic alu_aux_in,
	// Operand selection
	output bbd_mode_e oper_mode_r,
	output logic [7:0] oper_addr_r,
	output logic [2:0] oper_reg_r,
	// Results
	output logic done_r,
	output logic jump_r,
	output logic call_r,
	output logic [15:0] jump_target_r,
	output logic [15:0] ret_addr_r,
	output logic mem_wr_r,
	output logic [7:0] mem_wr_data_r,
	output logic bit_wr_r,
	output logic bit_wr_val_r,
	output logic brk_r,
	output logic bad_op_r,
	// Flags
	output logic carry_flag,
	output logic overflow_flag,
	output logic aux_carry_flag
);
	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	bbd_state_e state_r, state_nxt;
	bbd_cls_e cls_r, dec_cls;
	bbd_mode_e dec_mode;
	logic [1:0] nbytes_r, dec_nbytes;
	logic [2:0] ncyc_r, dec_ncyc, cnt_r;
	logic [7:0] op_r, b2_r, b3_r;
	logic [15:0] pc_r;
	logic take, finish, last_byte, stall;
	logic [7:0] b2_v, b3_v, rel_v, cmp_a, cmp_b, dec_v;

	bbd_op_decode u_dec (
		.op(fetch_byte),
		.cls(dec_cls),
		.nbytes(dec_nbytes),
		.ncyc(dec_ncyc),
		.mode(dec_mode)
	);

	// A byte is taken only while ready; the opcode only in idle
	assign take = (state_r == ST_IDLE) && fetch_valid && fetch_ready_r;
	assign stall = ((state_r == ST_FETCH2) || (state_r == ST_FETCH3)) && !fetch_valid;
	assign last_byte = ((state_r == ST_FETCH2) && (nbytes_r == LEN_2)) || (state_r == ST_FETCH3);
	// Finish on the edge that closes the last cycle of the instruction
	assign finish = (take && dec_ncyc == CYC_ONE) ||
		((state_r == ST_EXEC || (last_byte && fetch_valid)) && cnt_r == ncyc_r - 3'h1);

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take && dec_ncyc != CYC_ONE) begin
					state_nxt = (dec_nbytes == LEN_1) ? ST_EXEC : ST_FETCH2;
				end
			end
			ST_FETCH2: begin
				if (fetch_valid) begin
					state_nxt = (nbytes_r == LEN_3) ? ST_FETCH3 : ST_EXEC;
				end
			end
			ST_FETCH3: begin
				if (fetch_valid) begin
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: state_nxt = ST_EXEC;
			default: state_nxt = ST_IDLE;
		endcase
		if (finish) begin
			state_nxt = ST_IDLE;
		end
	end

	// State, ready and cycle count; a stalled fetch freezes the count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			fetch_ready_r <= 1'b0;
			cnt_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			fetch_ready_r <= (state_nxt != ST_EXEC);
			if (take) begin
				cnt_r <= 3'h1;
			end else if (state_r != ST_IDLE && !stall) begin
				cnt_r <= cnt_r + 3'h1;
			end
		end
	end

	// Instruction bytes and operand selection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cls_r <= CL_NONE;
			nbytes_r <= LEN_1;
			ncyc_r <= CYC_ONE;
			op_r <= 8'h00;
			b2_r <= 8'h00;
			b3_r <= 8'h00;
			pc_r <= 16'h0000;
			oper_mode_r <= MD_NONE;
			oper_addr_r <= 8'h00;
			oper_reg_r <= 3'h0;
		end else begin
			if (take) begin
				cls_r <= dec_cls;
				nbytes_r <= dec_nbytes;
				ncyc_r <= dec_ncyc;
				op_r <= fetch_byte;
				pc_r <= fetch_pc;
				oper_mode_r <= dec_mode;
				oper_reg_r <= fetch_byte[2:0];
			end
			if (state_r == ST_FETCH2 && fetch_valid) begin
				b2_r <= fetch_byte;
				oper_addr_r <= fetch_byte;
			end
			if (state_r == ST_FETCH3 && fetch_valid) begin
				b3_r <= fetch_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Execution
	// ----------------------------------------------------------------
	// Bytes arriving on the finishing edge are used straight from the bus
	assign b2_v = (state_r == ST_FETCH2) ? fetch_byte : b2_r;
	assign b3_v = (state_r == ST_FETCH3) ? fetch_byte : b3_r;
	assign rel_v = (nbytes_r == LEN_3) ? b3_v : b2_v;
	assign cmp_a = (cls_r == CL_CJ_MEM) ? mem_in : acc_in;
	assign cmp_b = (cls_r == CL_CJ_DIR) ? mem_in : b2_v;
	assign dec_v = mem_in - 8'h01;

	logic br_take, is_jump, carry_upd, carry_nxt;
	logic [15:0] pc_after, rel_tgt, jmp_tgt;
	assign pc_after = pc_r + {14'h0000, nbytes_r};
	assign rel_tgt = pc_after + {{8{rel_v[7]}}, rel_v};

	// Branch decision, target and new carry for the finishing instruction
	always_comb begin
		br_take = 1'b0;
		is_jump = 1'b1;
		jmp_tgt = rel_tgt;
		carry_upd = 1'b0;
		carry_nxt = carry_flag;
		case (cls_r)
			CL_ABSCALL, CL_ABSJMP: begin
				br_take = 1'b1;
				jmp_tgt = {pc_after[15:11], op_r[ABS_HI_MSB:ABS_HI_LSB], b2_v};
			end
			CL_RJMP: br_take = 1'b1;
			CL_JMPI: begin
				br_take = 1'b1;
				jmp_tgt = data_pointer_16 + {8'h00, acc_in};
			end
			CL_JZ: br_take = (acc_in == 8'h00);
			CL_JNZ: br_take = (acc_in != 8'h00);
			CL_JC: br_take = carry_flag;
			CL_JNC: br_take = !carry_flag;
			CL_JB, CL_JBCL: br_take = bit_in;
			CL_JNB: br_take = !bit_in;
			CL_CJ_DIR, CL_CJ_IMM, CL_CJ_MEM: begin
				br_take = (cmp_a != cmp_b);
				carry_upd = 1'b1;
				carry_nxt = (cmp_a < cmp_b);
			end
			CL_DJ_REG, CL_DJ_DIR: br_take = (dec_v != 8'h00);
			default: begin
				is_jump = 1'b0;
				carry_upd = 1'b1;
				case (cls_r)
					CL_ANL: carry_nxt = carry_flag & bit_in;
					CL_ANLN: carry_nxt = carry_flag & !bit_in;
					CL_ORL: carry_nxt = carry_flag | bit_in;
					CL_ORLN: carry_nxt = carry_flag | !bit_in;
					CL_MOVCB: carry_nxt = bit_in;
					CL_SETC: carry_nxt = 1'b1;
					CL_CLRC: carry_nxt = 1'b0;
					CL_CPLC: carry_nxt = !carry_flag;
					default: carry_upd = 1'b0;
				endcase
			end
		endcase
		br_take = br_take && is_jump;
	end

	// Result pulses, all for one cycle after the finishing edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r <= 1'b0;
			jump_r <= 1'b0;
			call_r <= 1'b0;
			jump_target_r <= 16'h0000;
			ret_addr_r <= 16'h0000;
			mem_wr_r <= 1'b0;
			mem_wr_data_r <= 8'h00;
			bit_wr_r <= 1'b0;
			bit_wr_val_r <= 1'b0;
			brk_r <= 1'b0;
			bad_op_r <= 1'b0;
		end else begin
			done_r <= finish;
			jump_r <= finish && !take && br_take;
			call_r <= finish && !take && (cls_r == CL_ABSCALL);
			mem_wr_r <= finish && !take && (cls_r == CL_DJ_REG || cls_r == CL_DJ_DIR);
			bit_wr_r <= finish && !take && ((cls_r == CL_JBCL && bit_in) || cls_r == CL_MOVBC);
			// Breakpoint and foreign opcodes are single-cycle and finish on the take edge
			brk_r <= take && dec_cls == CL_BRK && debug_mode_in;
			bad_op_r <= take && dec_cls == CL_NONE;
			if (finish && !take) begin
				jump_target_r <= jmp_tgt;
				ret_addr_r <= pc_after;
				mem_wr_data_r <= dec_v;
				bit_wr_val_r <= (cls_r == CL_MOVBC) ? carry_flag : 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Program status flags
	// ----------------------------------------------------------------
	// A single-cycle take or a carry-updating finish wins; an arithmetic-unit report in that cycle is dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_flag <= RST_FLAG;
			overflow_flag <= RST_FLAG;
			aux_carry_flag <= RST_FLAG;
		end else if (take && dec_ncyc == CYC_ONE) begin
			case (dec_cls)
				CL_SETC: carry_flag <= 1'b1;
				CL_CLRC: carry_flag <= 1'b0;
				CL_CPLC: carry_flag <= !carry_flag;
				default: carry_flag <= carry_flag;
			endcase
		end else if (finish && carry_upd) begin
			carry_flag <= carry_nxt;
		end else if (alu_valid_in) begin
			case (alu_kind_in)
				ALU_FULL: begin
					carry_flag <= alu_carry_in;
					overflow_flag <= alu_ovf_in;
					aux_carry_flag <= alu_aux_in;
				end
				ALU_MULDIV: begin
					carry_flag <= 1'b0;
					overflow_flag <= alu_ovf_in;
				end
				ALU_C_ONLY: carry_flag <= alu_carry_in;
				default: carry_flag <= carry_flag;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_two(logic [7:0] o);
		take && fetch_byte == o ##1 fetch_valid;
	endsequence
	sequence s_three(logic [7:0] o);
		s_two(o) ##1 fetch_valid;
	endsequence

	a_abs_target: assert property (done_r && jump_r && op_r[4:0] == ABS_JMP_LO |->
		jump_target_r[10:0] == {op_r[7:5], b2_r}) else $error("absolute target bits wrong");
	a_rel_three: assert property (s_two(OP_RJMP) |-> ##2 (done_r && jump_r))
		else $error("relative jump not done in three cycles");
	a_ind_sum: assert property (take && fetch_byte == OP_JMPI |-> ##2 (done_r && jump_r &&
		jump_target_r == $past(data_pointer_16) + {8'h00, $past(acc_in)})) else $error("indirect jump wrong");
	a_zero_branch: assert property (done_r && op_r == OP_JZ |-> jump_r == ($past(acc_in) == 8'h00))
		else $error("zero branch wrong");
	a_carry_branch: assert property (done_r && op_r == OP_JC |-> jump_r == $past(carry_flag))
		else $error("carry branch wrong");
	a_bit_four: assert property (s_three(OP_JB) |-> !done_r ##1 !done_r ##1 done_r)
		else $error("bit branch not done in four cycles");
	a_bit_clear: assert property (done_r && op_r == OP_JBCL && jump_r |-> bit_wr_r && !bit_wr_val_r)
		else $error("tested bit not cleared");
	a_cmp_carry: assert property (done_r && op_r == OP_CJ_IMM |->
		carry_flag == ($past(acc_in) < b2_r) && $stable(overflow_flag)) else $error("compare flags wrong");
	a_dec_write: assert property (done_r && cls_r == CL_DJ_REG |-> mem_wr_r &&
		mem_wr_data_r == $past(mem_in) - 8'h01) else $error("decrement write wrong");
	a_muldiv_carry: assert property (alu_valid_in && alu_kind_in == ALU_MULDIV && !finish |=>
		!carry_flag && overflow_flag == $past(alu_ovf_in)) else $error("multiply flags wrong");
	a_brk_one: assert property (take && fetch_byte == OP_BRK && debug_mode_in |=> brk_r && done_r)
		else $error("breakpoint not taken in one cycle");
endmodule
`default_nettype wire

// [sim/bbd_fetch_model.sv]
// Fetch-side partner: offers up to three instruction bytes, one per take.
// Assumes the bench sets the bytes and pulses start for one clock cycle.
`timescale 1ns/1ps
`default_nettype none
module bbd_fetch_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bench control
	input wire logic start,
	input wire logic [7:0] b0,
	input wire logic [7:0] b1,
	input wire logic [7:0] b2,
	input wire logic [1:0] nb,
	input wire logic [1:0] stall,
	// Fetch port
	input wire logic fetch_ready_r,
	output logic fetch_valid,
	output logic [7:0] fetch_byte
);
	logic act_r;
	logic [1:0] idx_r;
	logic [1:0] gap_r;
	logic [7:0] last_r;
	// ------------------------------------------------------------
	// Byte sequencing
	// ------------------------------------------------------------
	// Advance on each taken byte; a stall gap delays the next one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_r <= 1'b0;
			idx_r <= 2'h0;
			gap_r <= 2'h0;
			last_r <= 8'h00;
		end else if (start) begin
			act_r <= 1'b1;
			idx_r <= 2'h0;
			gap_r <= 2'h0;
		end else if (fetch_valid && fetch_ready_r) begin
			last_r <= fetch_byte;
			idx_r <= idx_r + 2'h1;
			gap_r <= stall;
			act_r <= (idx_r + 2'h1) != nb;
		end else if (gap_r != 2'h0) begin
			gap_r <= gap_r - 2'h1;
		end
	end
	assign fetch_valid = act_r && (gap_r == 2'h0);
	// Idle lines show the inverse of the last byte, so stale data never looks valid
	assign fetch_byte = !fetch_valid ? ~last_r : (idx_r == 2'h0) ? b0 : (idx_r == 2'h1) ? b1 : b2;
endmodule
`default_nettype wire

// [sim/test_bbd_core.sv]
// Self-checking bench for the branch and bit-operation unit.
// Assumes the fetch partner model; operands are held steady per instruction.
`timescale 1ns/1ps
`default_nettype none
module test_bbd_core import bbd_pkg::*;;
	typedef struct {logic [7:0] op, b1, b2; logic [1:0] nb; logic [2:0] cyc; logic [7:0] acc, mem;
		logic [3:0] f; logic [15:0] tgt;} bbd_row_s;
	logic core_clk = 1'b0, rst_n = 1'b0, start = 1'b0, fv, rdy, bit_in = 1'b0, dbg = 1'b1;
	logic [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00, fb, acc_in = 8'h00, mem_in = 8'h00, mwd;
	logic [1:0] nb = 2'h1, stall = 2'h0;
	logic alu_v = 1'b0, a_cf = 1'b0, a_vf = 1'b0, a_hf = 1'b0, done, jmp, call, mwr, bwr, bval, brk, bad, cf, vf, hf;
	bbd_alu_e alu_k = ALU_NONE;
	bbd_mode_e omode;
	logic [15:0] tgt, cyc, ra;
	logic g_j, g_c, g_mw, g_bw, g_bv, g_brk, g_bad;
	logic [7:0] g_md;
	logic [15:0] g_t, g_ra;
	int n_errors = 0, comparisons = 0;
	bbd_row_s rows[25] = '{
		'{8'h71, 8'h34, 8'h00, 2'h2, 3'h6, 8'h00, 8'h00, 4'h2, 16'h1334}, '{8'hE1, 8'h5A, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h2, 16'h175A},
		'{8'h80, 8'hF0, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h2, 16'h0FF2}, '{8'h73, 8'h00, 8'h00, 2'h1, 3'h2, 8'h22, 8'h00, 4'h2, 16'h2022},
		'{8'h60, 8'h10, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h2, 16'h1012}, '{8'h60, 8'h10, 8'h00, 2'h2, 3'h3, 8'h01, 8'h00, 4'h0, 16'h0000},
		'{8'h70, 8'h10, 8'h00, 2'h2, 3'h3, 8'h01, 8'h00, 4'h2, 16'h1012}, '{8'h40, 8'h10, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h7, 16'h1012},
		'{8'h50, 8'h10, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h5, 16'h0000}, '{8'h20, 8'h44, 8'h10, 2'h3, 3'h4, 8'h00, 8'h00, 4'hA, 16'h1013},
		'{8'h30, 8'h44, 8'h10, 2'h3, 3'h4, 8'h00, 8'h00, 4'h8, 16'h0000}, '{8'h10, 8'h44, 8'h10, 2'h3, 3'h4, 8'h00, 8'h00, 4'hA, 16'h1013},
		'{8'hB5, 8'h30, 8'h10, 2'h3, 3'h4, 8'h05, 8'h07, 4'h3, 16'h1013}, '{8'hB4, 8'h09, 8'h10, 2'h3, 3'h4, 8'h09, 8'h00, 4'h0, 16'h0000},
		'{8'hBB, 8'h02, 8'h10, 2'h3, 3'h4, 8'h00, 8'h03, 4'h2, 16'h1013}, '{8'hB7, 8'h02, 8'h10, 2'h3, 3'h4, 8'h00, 8'h02, 4'h4, 16'h0000},
		'{8'hDA, 8'h10, 8'h00, 2'h2, 3'h3, 8'h00, 8'h01, 4'h0, 16'h0000}, '{8'hD5, 8'h30, 8'h10, 2'h3, 3'h4, 8'h00, 8'h05, 4'h2, 16'h1013},
		'{8'h82, 8'h44, 8'h00, 2'h2, 3'h2, 8'h00, 8'h00, 4'h4, 16'h0000}, '{8'hB0, 8'h44, 8'h00, 2'h2, 3'h2, 8'h00, 8'h00, 4'h5, 16'h0000},
		'{8'h72, 8'h44, 8'h00, 2'h2, 3'h2, 8'h00, 8'h00, 4'h9, 16'h0000}, '{8'hA0, 8'h44, 8'h00, 2'h2, 3'h2, 8'h00, 8'h00, 4'h8, 16'h0000},
		'{8'hA2, 8'h44, 8'h00, 2'h2, 3'h2, 8'h00, 8'h00, 4'h9, 16'h0000}, '{8'h92, 8'h44, 8'h00, 2'h2, 3'h3, 8'h00, 8'h00, 4'h5, 16'h0000},
		'{8'hA5, 8'h00, 8'h00, 2'h1, 3'h1, 8'h00, 8'h00, 4'h0, 16'h0000}};
	// ------------------------------------------------------------
	// Clock, partner and unit under test
	// ------------------------------------------------------------
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	bbd_fetch_model fetch (.core_clk(core_clk), .rst_n(rst_n), .start(start), .b0(b0), .b1(b1), .b2(b2), .nb(nb),
		.stall(stall), .fetch_ready_r(rdy), .fetch_valid(fv), .fetch_byte(fb));
	bbd_core dut (.core_clk(core_clk), .rst_n(rst_n), .fetch_valid(fv), .fetch_byte(fb), .fetch_pc(16'h1000),
		.fetch_ready_r(rdy), .acc_in(acc_in), .data_pointer_16(16'h2000), .mem_in(mem_in), .bit_in(bit_in),
		.debug_mode_in(dbg), .alu_valid_in(alu_v), .alu_kind_in(alu_k), .alu_carry_in(a_cf), .alu_ovf_in(a_vf),
		.alu_aux_in(a_hf), .oper_mode_r(omode), .oper_addr_r(), .oper_reg_r(), .done_r(done), .jump_r(jmp),
		.call_r(call), .jump_target_r(tgt), .ret_addr_r(ra), .mem_wr_r(mwr), .mem_wr_data_r(mwd), .bit_wr_r(bwr),
		.bit_wr_val_r(bval), .brk_r(brk), .bad_op_r(bad), .carry_flag(cf), .overflow_flag(vf), .aux_carry_flag(hf));
	// ------------------------------------------------------------
	// Compare tasks and verdict
	// ------------------------------------------------------------
	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Issue one instruction; counts edges from the opcode take to done (bounded)
	task automatic run_op(input logic [7:0] o, input logic [7:0] x, input logic [7:0] y, input logic [1:0] n);
		@(posedge core_clk) #1;
		{b0, b1, b2, nb, start} = {o, x, y, n, 1'b1};
		@(posedge core_clk) #1;
		start = 1'b0;
		cyc = 16'h0000;
		while (cyc < 16'h0014 && done !== 1'b1) begin
			@(posedge core_clk) #1;
			cyc++;
		end
		{g_j, g_c, g_mw, g_md, g_bw, g_bv, g_brk, g_bad, g_t, g_ra} = {jmp, call, mwr, mwd, bwr, bval, brk, bad, tgt, ra};
	endtask
	// Watchdog: the whole run needs well under a millisecond
	initial begin
		#1_000_000;
		n_errors++;
		final_report();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		chk_bit("done in reset", 1'b0, done);
		chk_word("mode in reset", 16'(MD_NONE), 16'(omode));
		#1 rst_n = 1'b1;
		foreach (rows[i]) begin
			{acc_in, mem_in, bit_in} = {rows[i].acc, rows[i].mem, rows[i].f[3]};
			run_op(rows[i].f[2] ? 8'hD3 : 8'hC3, 8'h00, 8'h00, 2'h1);
			chk_bit("preset carry", rows[i].f[2], cf);
			run_op(rows[i].op, rows[i].b1, rows[i].b2, rows[i].nb);
			chk_word("cycles", {13'h0000, rows[i].cyc}, cyc);
			chk_bit("jump", rows[i].f[1], g_j);
			if (rows[i].f[1]) chk_word("target", rows[i].tgt, g_t);
			chk_bit("call", rows[i].op[4:0] == 5'h11, g_c);
			if (g_c === 1'b1) chk_word("return", 16'h1002, g_ra);
			chk_bit("carry", rows[i].f[0], cf);
			chk_bit("bit write", (rows[i].op == 8'h10 && rows[i].f[3]) || rows[i].op == 8'h92, g_bw);
			if (g_bw === 1'b1) chk_bit("bit value", rows[i].op == 8'h92 && rows[i].f[2], g_bv);
			chk_bit("mem write", rows[i].op == 8'hD5 || rows[i].op[7:3] == 5'h1B, g_mw);
			if (g_mw === 1'b1) chk_word("mem data", {8'h00, rows[i].mem - 8'h01}, {8'h00, g_md});
			chk_bit("breakpoint", rows[i].op == 8'hA5, g_brk);
		end
		// Breakpoint outside debug mode must not stop the core
		dbg = 1'b0;
		run_op(8'hA5, 8'h00, 8'h00, 2'h1);
		chk_bit("breakpoint off", 1'b0, g_brk);
		dbg = 1'b1;
		// Slow fetch: two idle cycles before the offset byte stretch the jump
		stall = 2'h2;
		run_op(8'h80, 8'h10, 8'h00, 2'h2);
		chk_word("stalled cycles", 16'h0005, cyc);
		stall = 2'h0;
		// Arithmetic flag reports: full, carry-only, then multiply/divide
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk) #1;
			alu_k = (k == 0) ? ALU_FULL : (k == 1) ? ALU_C_ONLY : ALU_MULDIV;
			{alu_v, a_cf, a_vf, a_hf} = (k == 1) ? 4'h8 : 4'hF;
			@(posedge core_clk) #1;
			alu_v = 1'b0;
			chk_bit("alu carry", k == 0, cf);
			chk_bit("alu overflow", 1'b1, vf);
			chk_bit("alu aux carry", 1'b1, hf);
		end
		// Carry-bit logic must keep the other two flags
		bit_in = 1'b1;
		run_op(8'h72, 8'h44, 8'h00, 2'h2);
		chk_bit("orl carry", 1'b1, cf);
		chk_bit("orl keeps overflow", 1'b1, vf);
		chk_bit("orl keeps aux", 1'b1, hf);
		// Complementing carry is the one single-cycle carry op the rows never reach
		run_op(8'hB3, 8'h00, 8'h00, 2'h1);
		chk_bit("cpl carry", 1'b0, cf);
		chk_bit("cpl keeps overflow", 1'b1, vf);
		// An opcode outside this unit finishes in one cycle and only raises the bad-opcode pulse
		run_op(8'h00, 8'h00, 8'h00, 2'h1);
		chk_bit("foreign opcode", 1'b1, g_bad);
		final_report();
	end
endmodule
`default_nettype wire
